// ==== design/cfg_if.sv ====
`default_nettype none
interface cfg_if;
  import pci_cfg_pkg::*;
  logic we;
  cbe_t be;
  idx_t widx;
  idx_t ridx;
  ad_t  wdata;
  ad_t  rdata;
  modport ctl (output we, be, widx, ridx, wdata, input rdata);
  modport mem (input we, be, widx, ridx, wdata, output rdata);
endinterface : cfg_if
`default_nettype wire

// ==== design/cfg_mem.sv ====
`default_nettype none
module cfg_mem (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  cfg_if.mem        port
);
  import pci_cfg_pkg::*;
  ad_t mem_q [CFG_DEPTH];
  ad_t rdata_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (port.we) begin
      for (int b = 0; b < 4; b++) begin
        if (port.be[b]) begin
          mem_q[port.widx][b*8 +: 8] <= port.wdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[port.ridx];
    end
  end

  assign port.rdata = rdata_q;
endmodule : cfg_mem
`default_nettype wire

// ==== design/pci_cfg_pkg.sv ====
`default_nettype none
package pci_cfg_pkg;
  typedef logic [31:0] ad_t;
  typedef logic [3:0]  cbe_t;
  typedef logic [4:0]  idx_t;

  localparam int   CFG_DEPTH   = 32;
  localparam cbe_t CMD_CFG_RD  = 4'hA;
  localparam cbe_t CMD_CFG_WR  = 4'hB;

  // dword indexes of config space
  localparam idx_t IDX_ID      = 5'h00;
  localparam idx_t IDX_CMD     = 5'h01;
  localparam idx_t IDX_CLASS   = 5'h02;
  localparam idx_t IDX_CAP     = 5'h0D;
  localparam idx_t IDX_PMC     = 5'h10;
  localparam idx_t IDX_PMCSR   = 5'h11;

  // identity value is arbitrary
  localparam ad_t  ID_VAL      = 32'h5A5A_1234;
  localparam ad_t  CLASS_VAL   = 32'h0700_0200;
  localparam ad_t  CAP_VAL     = 32'h0000_0040;
  localparam ad_t  PMC_VAL     = 32'h4002_0001;

  localparam int   CMD_PERR_B  = 6;
  localparam int   CMD_SERR_B  = 8;
  localparam int   CMD_INTD_B  = 10;
  localparam int   STAT_INT_B  = 19;
  localparam int   STAT_CAP_B  = 20;
  localparam int   STAT_66_B   = 21;
  localparam int   STAT_SERR_B = 30;
  localparam int   STAT_DPE_B  = 31;
  localparam int   PM_EN_B     = 8;
  localparam int   PM_ST_B     = 15;
  localparam logic [1:0] PM_D3HOT = 2'h3;
  localparam logic [1:0] PM_D0    = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CLAIM = 3'h1,
    ST_DATA  = 3'h3,
    ST_HOLD  = 3'h2,
    ST_TURN  = 3'h6
  } state_t;

  function automatic logic even_par(input ad_t ad, input cbe_t cbe);
    even_par = ^{ad, cbe};
  endfunction : even_par
endpackage : pci_cfg_pkg
`default_nettype wire

// ==== design/pci_target.sv ====
`default_nettype none
module pci_target (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire pci_cfg_pkg::ad_t  ad_i,
  output logic                   ad_oe_o,
  output pci_cfg_pkg::ad_t       ad_o,
  input  wire pci_cfg_pkg::cbe_t cbe_n_i,
  input  wire logic              frame_n_i,
  input  wire logic              irdy_n_i,
  input  wire logic              idsel_i,
  output logic                   trdy_n_o,
  output logic                   trdy_oe_o,
  output logic                   stop_n_o,
  output logic                   stop_oe_o,
  output logic                   devsel_n_o,
  output logic                   devsel_oe_o,
  input  wire logic              par_i,
  output logic                   par_o,
  output logic                   par_oe_o,
  output logic                   perr_n_o,
  output logic                   perr_oe_o,
  output logic                   serr_n_o,
  output logic                   serr_oe_o,
  output logic                   inta_n_o,
  output logic                   inta_oe_o,
  output logic                   pme_n_o,
  output logic                   pme_oe_o,
  input  wire logic              irq_i,
  input  wire logic [7:0]        wake_event_i
);
  import pci_cfg_pkg::*;

  state_t     state_q;
  logic       idle_q, rd_q, chk_q, chk_data_q, perr_hi_q;
  logic       exp_q, perr_en_q, serr_en_q, int_dis_q;
  logic       stat_dpe_q, stat_serr_q, pme_en_q, pme_st_q;
  logic [1:0] pm_state_q;
  idx_t       idx_q;
  ad_t        ad_q, rd_ov;
  logic       addr_hit, addr_phase, xfer, xfer_wr, perr_err, addr_err, wake;
  cfg_if      cfg ();

  cfg_mem u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .port    (cfg)
  );

  // a new address only after one idle bus cycle; fast back-to-back is not claimed
  assign addr_phase = (state_q == ST_IDLE) && !frame_n_i && idle_q;
  assign addr_hit   = addr_phase && idsel_i && (ad_i[1:0] == 2'h0) &&
                      (cbe_n_i == CMD_CFG_RD || cbe_n_i == CMD_CFG_WR);
  assign xfer       = (state_q == ST_DATA) && !irdy_n_i;
  assign xfer_wr    = xfer && !rd_q;
  assign perr_err   = chk_q && chk_data_q && (par_i != exp_q);
  assign addr_err   = chk_q && !chk_data_q && (par_i != exp_q);
  assign wake       = (|wake_event_i) && (pm_state_q == PM_D3HOT) && pme_en_q;

  assign cfg.ridx  = ad_i[6:2];
  assign cfg.widx  = idx_q;
  assign cfg.we    = xfer_wr;
  assign cfg.be    = ~cbe_n_i;
  assign cfg.wdata = ad_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  if (addr_hit) state_q <= ST_CLAIM;
        ST_CLAIM: state_q <= ST_DATA;
        ST_DATA:  if (!irdy_n_i) state_q <= frame_n_i ? ST_TURN : ST_HOLD;
        ST_HOLD:  if (frame_n_i) state_q <= ST_TURN;
        ST_TURN:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_q <= 1'b1;
      rd_q   <= 1'b0;
      idx_q  <= '0;
    end else begin
      idle_q <= frame_n_i && irdy_n_i;
      if (addr_hit) begin
        rd_q  <= (cbe_n_i == CMD_CFG_RD);
        idx_q <= ad_i[6:2];
      end
    end
  end

  always_comb begin
    rd_ov = cfg.rdata;
    unique case (idx_q)
      IDX_ID:    rd_ov = ID_VAL;
      IDX_CLASS: rd_ov = CLASS_VAL;
      IDX_CAP:   rd_ov = CAP_VAL;
      IDX_PMC:   rd_ov = PMC_VAL;
      IDX_CMD: begin
        rd_ov              = '0;
        rd_ov[CMD_PERR_B]  = perr_en_q;
        rd_ov[CMD_SERR_B]  = serr_en_q;
        rd_ov[CMD_INTD_B]  = int_dis_q;
        rd_ov[STAT_INT_B]  = irq_i;
        rd_ov[STAT_CAP_B]  = 1'b1;
        rd_ov[STAT_66_B]   = 1'b1;
        rd_ov[STAT_SERR_B] = stat_serr_q;
        rd_ov[STAT_DPE_B]  = stat_dpe_q;
      end
      IDX_PMCSR: begin
        rd_ov          = '0;
        rd_ov[1:0]     = pm_state_q;
        rd_ov[PM_EN_B] = pme_en_q;
        rd_ov[PM_ST_B] = pme_st_q;
      end
      default: rd_ov = cfg.rdata;
    endcase
  end

  // read data goes out one cycle after the claim: the claim cycle is the turnaround
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ad_q     <= '0;
      ad_oe_o  <= 1'b0;
      par_o    <= 1'b0;
      par_oe_o <= 1'b0;
    end else begin
      if (state_q == ST_CLAIM) begin
        ad_q    <= rd_ov;
        ad_oe_o <= rd_q;
      end else if (xfer) begin
        ad_oe_o <= 1'b0;
      end
      par_o    <= even_par(ad_q, cbe_n_i);
      par_oe_o <= ad_oe_o;
    end
  end
  assign ad_o = ad_q;

  // every access is one data phase; STOP with TRDY disconnects a burst cleanly
  assign devsel_n_o  = !(state_q == ST_CLAIM || state_q == ST_DATA ||
                         state_q == ST_HOLD);
  assign trdy_n_o    = !(state_q == ST_DATA);
  assign stop_n_o    = !(state_q == ST_DATA || state_q == ST_HOLD);
  assign devsel_oe_o = (state_q != ST_IDLE);
  assign trdy_oe_o   = (state_q != ST_IDLE);
  assign stop_oe_o   = (state_q != ST_IDLE);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chk_q      <= 1'b0;
      chk_data_q <= 1'b0;
      exp_q      <= 1'b0;
      perr_n_o   <= 1'b1;
      perr_hi_q  <= 1'b0;
      serr_oe_o  <= 1'b0;
    end else begin
      chk_q      <= addr_hit || xfer_wr;
      chk_data_q <= xfer_wr;
      exp_q      <= even_par(ad_i, cbe_n_i);
      perr_n_o   <= !(perr_err && perr_en_q);
      perr_hi_q  <= !perr_n_o;
      serr_oe_o  <= addr_err && serr_en_q && perr_en_q;
    end
  end
  // perr is driven high one cycle before release so the wire does not float low
  assign perr_oe_o = !perr_n_o || perr_hi_q;
  assign serr_n_o  = 1'b0;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      perr_en_q   <= 1'b0;
      serr_en_q   <= 1'b0;
      int_dis_q   <= 1'b0;
      stat_dpe_q  <= 1'b0;
      stat_serr_q <= 1'b0;
    end else begin
      if (xfer_wr && idx_q == IDX_CMD && cfg.be[0]) perr_en_q <= ad_i[CMD_PERR_B];
      if (xfer_wr && idx_q == IDX_CMD && cfg.be[1]) begin
        serr_en_q <= ad_i[CMD_SERR_B];
        int_dis_q <= ad_i[CMD_INTD_B];
      end
      // hardware set wins over a write-one clear in the same cycle
      if (perr_err || addr_err) begin
        stat_dpe_q <= 1'b1;
      end else if (xfer_wr && idx_q == IDX_CMD && cfg.be[3] && ad_i[STAT_DPE_B]) begin
        stat_dpe_q <= 1'b0;
      end
      if (addr_err && serr_en_q && perr_en_q) begin
        stat_serr_q <= 1'b1;
      end else if (xfer_wr && idx_q == IDX_CMD && cfg.be[3] && ad_i[STAT_SERR_B]) begin
        stat_serr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pm_state_q <= PM_D0;
      pme_en_q   <= 1'b0;
      pme_st_q   <= 1'b0;
      inta_oe_o  <= 1'b0;
    end else begin
      if (xfer_wr && idx_q == IDX_PMCSR && cfg.be[0]) pm_state_q <= ad_i[1:0];
      if (xfer_wr && idx_q == IDX_PMCSR && cfg.be[1]) pme_en_q <= ad_i[PM_EN_B];
      if (wake) begin
        pme_st_q <= 1'b1;
      end else if (xfer_wr && idx_q == IDX_PMCSR && cfg.be[1] && ad_i[PM_ST_B]) begin
        pme_st_q <= 1'b0;
      end
      inta_oe_o <= irq_i && !int_dis_q;
    end
  end
  assign pme_oe_o = pme_st_q && pme_en_q;
  assign pme_n_o  = 1'b0;
  assign inta_n_o = 1'b0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_defaults: assert property (
    $rose(rst_n_i) |-> state_q == ST_IDLE && !pme_oe_o && !inta_oe_o)
    else $error("not idle after reset");
  a_claim_timing: assert property ($fell(devsel_n_o) |-> $past(addr_hit))
    else $error("claim without decoded address");
  a_read_drive: assert property (state_q == ST_DATA |-> ad_oe_o == rd_q)
    else $error("AD drive does not follow direction");
  a_claim_data: assert property ($fell(devsel_n_o) |=> !trdy_n_o && !stop_n_o)
    else $error("no data phase after claim");
  a_cfg_idsel: assert property (state_q == ST_IDLE && !idsel_i |=> devsel_n_o)
    else $error("claimed without idsel");
  a_int_pin: assert property (irq_i && !int_dis_q |=> inta_oe_o)
    else $error("interrupt not driven");
  a_pme_wake: assert property (wake |=> pme_oe_o)
    else $error("wake event without PME");
  a_read_parity: assert property (par_oe_o |-> par_o == ^{$past(ad_o), $past(cbe_n_i)})
    else $error("bad read parity");
  a_perr_pulse: assert property (
    $fell(perr_n_o) |=> perr_n_o && perr_oe_o ##1 !perr_oe_o)
    else $error("perr pulse shape");
  a_serr_status: assert property (serr_oe_o |=> stat_serr_q)
    else $error("serr without status");
  a_turn_release: assert property (
    xfer && frame_n_i |=> devsel_n_o && devsel_oe_o ##1 !devsel_oe_o)
    else $error("bad release after last phase");

  c_cfg_read:  cover property (xfer && rd_q);
  c_cfg_write: cover property (xfer_wr && idx_q == IDX_PMCSR);
  c_hold:      cover property (state_q == ST_HOLD ##1 state_q == ST_TURN);
  c_pme:       cover property ($rose(pme_oe_o));
endmodule : pci_target
`default_nettype wire

// ==== verification/host_model.sv ====
`default_nettype none
module host_model (
  input  wire logic             clk_i,
  input  wire logic             trdy_n_i,
  input  wire logic             devsel_n_i,
  input  wire pci_cfg_pkg::ad_t ad_i,
  input  wire logic             par_i,
  output pci_cfg_pkg::ad_t      ad_o,
  output logic                  ad_en_o,
  output pci_cfg_pkg::cbe_t     cbe_n_o,
  output logic                  frame_n_o,
  output logic                  irdy_n_o,
  output logic                  par_o,
  output logic                  par_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pci_cfg_pkg::*;
  logic bad_q;
  initial begin
    {frame_n_o, irdy_n_o} = 2'h3;
    {ad_en_o, par_en_o, par_o, bad_q} = 4'h0;
    cbe_n_o = 4'hF;
    ad_o = '0;
  end
  // parity trails the lines it covers by one cycle
  always @(posedge clk_i) begin
    par_o    <= ^{ad_o, cbe_n_o} ^ bad_q;
    par_en_o <= ad_en_o;
  end
  task automatic xfer(input cbe_t c, input ad_t a, input cbe_t be, input ad_t wd,
                      input logic [1:0] f, output ad_t rd, output logic hit, output logic rp);
    int n;
    hit = 1'b0;
    n = 0;
    @(posedge clk_i);
    frame_n_o <= 1'b0;
    ad_o      <= a;
    ad_en_o   <= 1'b1;
    cbe_n_o   <= c;
    bad_q     <= f[1];
    @(posedge clk_i);
    // single data phase, so frame rises as irdy falls
    frame_n_o <= 1'b1;
    irdy_n_o  <= 1'b0;
    cbe_n_o   <= ~be;
    ad_o      <= wd;
    ad_en_o   <= c[0];
    bad_q     <= f[0];
    do begin
      @(posedge clk_i);
      n++;
      hit |= !devsel_n_i;
    end while (trdy_n_i && n < 8);
    rd = ad_i;
    irdy_n_o <= 1'b1;
    ad_en_o  <= 1'b0;
    bad_q    <= 1'b0;
    @(posedge clk_i);
    rp = par_i;
    repeat (2) @(posedge clk_i);
  endtask : xfer
endmodule : host_model
`default_nettype wire

// ==== verification/pci_target_interface_pme_bench.sv ====
`default_nettype none
module pci_target_interface_pme_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pci_cfg_pkg::*;
  logic clk_i, rst_n_i, idsel_i, irq_i, frame_n_i, irdy_n_i, ad_oe_o, trdy_n_o, trdy_oe_o;
  logic stop_n_o, stop_oe_o, devsel_n_o, devsel_oe_o, par_o, par_oe_o, perr_n_o, perr_oe_o;
  logic serr_n_o, serr_oe_o, inta_n_o, inta_oe_o, pme_n_o, pme_oe_o, m_en, m_par, m_pen;
  logic par_i;
  logic       par_last = 1'b0;
  logic [7:0] wake_event_i;
  cbe_t       cbe_n_i;
  ad_t        ad_i, ad_o, m_ad;
  ad_t        ad_last = '0;
  ad_t        perr_cnt = '0;
  ad_t        serr_cnt = '0;
  ad_t        stop_cnt = '0;
  int         num_errors = 0;
  int         checks_done = 0;
  // a released line toggles so stale data never passes for a read
  assign ad_i  = ad_oe_o ? ad_o : (m_en ? m_ad : ~ad_last);
  assign par_i = par_oe_o ? par_o : (m_pen ? m_par : ~par_last);
  always @(posedge clk_i) begin
    ad_last  <= ad_i;
    par_last <= par_i;
    if (perr_oe_o && !perr_n_o) perr_cnt <= perr_cnt + 32'h1;
    if (serr_oe_o && !serr_n_o) serr_cnt <= serr_cnt + 32'h1;
    if (stop_oe_o && !stop_n_o && !trdy_n_o) stop_cnt <= stop_cnt + 32'h1;
  end
  pci_target dut_u (
    .clk_i, .rst_n_i, .ad_i, .ad_oe_o, .ad_o, .cbe_n_i, .frame_n_i, .irdy_n_i,
    .idsel_i, .trdy_n_o, .trdy_oe_o, .stop_n_o, .stop_oe_o, .devsel_n_o,
    .devsel_oe_o, .par_i, .par_o, .par_oe_o, .perr_n_o, .perr_oe_o, .serr_n_o,
    .serr_oe_o, .inta_n_o, .inta_oe_o, .pme_n_o, .pme_oe_o, .irq_i, .wake_event_i
  );
  host_model host_u (
    .clk_i, .trdy_n_i(trdy_n_o | !trdy_oe_o), .devsel_n_i(devsel_n_o | !devsel_oe_o),
    .ad_i, .par_i, .ad_o(m_ad), .ad_en_o(m_en), .cbe_n_o(cbe_n_i),
    .frame_n_o(frame_n_i), .irdy_n_o(irdy_n_i), .par_o(m_par), .par_en_o(m_pen)
  );
  function automatic ad_t ext(input logic x);
    return {31'h0, x};
  endfunction : ext
  task automatic chk(input string s, input ad_t e, input ad_t g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input idx_t i, input cbe_t be, input ad_t d);
    ad_t  r;
    logic h, p;
    host_u.xfer(CMD_CFG_WR, {25'h0, i, 2'h0}, be, d, 2'h0, r, h, p);
  endtask : wr
  task automatic rd(input string s, input idx_t i, input ad_t e);
    ad_t  r;
    logic h, p;
    host_u.xfer(CMD_CFG_RD, {25'h0, i, 2'h0}, 4'hF, '0, 2'h0, r, h, p);
    chk(s, e, r);
    chk(s, ext(^e), ext(p));
  endtask : rd
  task automatic probe(input string s, input cbe_t c, input logic e);
    ad_t  r;
    logic h, p;
    host_u.xfer(c, '0, 4'hF, '0, 2'h0, r, h, p);
    chk(s, ext(e), ext(h));
  endtask : probe
  task automatic t_defaults;
    rd("id", IDX_ID, ID_VAL);
    rd("class", IDX_CLASS, CLASS_VAL);
    rd("cap", IDX_CAP, CAP_VAL);
    rd("pmc", IDX_PMC, PMC_VAL);
    rd("status", IDX_CMD, 32'h0030_0000);
    rd("pmcsr", IDX_PMCSR, '0);
  endtask : t_defaults
  task automatic t_lanes;
    wr(5'h14, 4'hF, 32'h1234_5678);
    wr(5'h14, 4'h5, 32'hAAAA_AAAA);
    rd("lanes", 5'h14, 32'h12AA_56AA);
  endtask : t_lanes
  task automatic t_claim;
    ad_t s0;
    s0 = stop_cnt;
    idsel_i <= 1'b0;
    probe("idsel low", CMD_CFG_RD, 1'b0);
    idsel_i <= 1'b1;
    probe("memory cmd", 4'h6, 1'b0);
    chk("no stop", s0, stop_cnt);
    probe("config cmd", CMD_CFG_RD, 1'b1);
    chk("stop", s0 + 32'h1, stop_cnt);
  endtask : t_claim
  task automatic t_parity;
    ad_t  r, p0, s0;
    logic h, p;
    wr(IDX_CMD, 4'hF, 32'h0000_0140);
    p0 = perr_cnt;
    s0 = serr_cnt;
    host_u.xfer(CMD_CFG_WR, 32'h0000_0050, 4'hF, '0, 2'h1, r, h, p);
    chk("perr", 32'h1, perr_cnt - p0);
    host_u.xfer(CMD_CFG_RD, '0, 4'hF, '0, 2'h2, r, h, p);
    chk("serr", 32'h1, serr_cnt - s0);
    rd("err status", IDX_CMD, 32'hC030_0140);
    wr(IDX_CMD, 4'hF, 32'hC000_0000);
    rd("err cleared", IDX_CMD, 32'h0030_0000);
  endtask : t_parity
  task automatic t_irq;
    irq_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("inta", ext(1'b1), ext(inta_oe_o));
    chk("inta level", ext(1'b0), ext(inta_n_o));
    rd("irq status", IDX_CMD, 32'h0038_0000);
    wr(IDX_CMD, 4'hF, 32'h0000_0400);
    chk("inta masked", ext(1'b0), ext(inta_oe_o));
    irq_i <= 1'b0;
    wr(IDX_CMD, 4'hF, 32'h0000_0000);
  endtask : t_irq
  task automatic t_pme;
    ad_t pm[3] = '{32'h0000_0100, 32'h0000_0003, 32'h0000_0103};
    for (int i = 0; i < 3; i++) begin
      wr(IDX_PMCSR, 4'hF, pm[i]);
      wake_event_i <= 8'h20;
      @(posedge clk_i);
      wake_event_i <= 8'h00;
      repeat (3) @(posedge clk_i);
      chk("pme", ext(i == 2), ext(pme_oe_o));
    end
    chk("pme level", '0, ext(pme_n_o));
    rd("pme status", IDX_PMCSR, 32'h0000_8103);
  endtask : t_pme
  // second reset mid-run, with pme still pending
  task automatic t_reset;
    wr(5'h14, 4'hF, 32'hC3C3_3C3C);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk("pme reset", ext(1'b0), ext(pme_oe_o));
    rd("pmcsr reset", IDX_PMCSR, '0);
    rd("scratch reset", 5'h14, '0);
  endtask : t_reset
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    {rst_n_i, irq_i, idsel_i} = 3'h1;
    wake_event_i = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_defaults;
    t_lanes;
    t_claim;
    t_parity;
    t_irq;
    t_pme;
    t_reset;
    give_verdict;
  end
  // 28 transfers of under 16 cycles each
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    give_verdict;
  end
endmodule : pci_target_interface_pme_bench
`default_nettype wire
